// *** cs_timing_map.vh ***
// Register map, field positions and timing counts of the chip-select timing block
`ifndef CS_TIMING_MAP_VH
`define CS_TIMING_MAP_VH

// Register byte offsets
`define WAIT_CONTROL_2_OFS      4'h0
`define WAIT_CONTROL_3_OFS      4'h4
`define TIMING_STATUS_OFS       4'h8

// Writable bit masks, reserved bits stay zero
`define WAIT_CONTROL_2_WMASK    16'hDF0F
`define WAIT_CONTROL_3_WMASK    16'h3BFF

// Reset values
`define WAIT_CONTROL_2_RST      16'h000B
`define WAIT_CONTROL_3_RST      16'h0000

// wait_control_2 fields
`define RELEASE_DELAY_HI        15
`define RELEASE_DELAY_LO        14
`define EXT_WAIT_MASK_HI        12
`define EXT_WAIT_MASK_LO        8
`define IDLE_GAP_HI             3
`define IDLE_GAP_LO             2
`define WAIT_SEL_HI             1
`define WAIT_SEL_LO             0

// wait_control_3 fields
`define SETUP_LEN_HI            13
`define SETUP_LEN_LO            11
`define HOLD_LEN_HI             9
`define HOLD_LEN_LO             8

// Long wait clamp range
`define LONG_WAIT_MIN           4'h3
`define LONG_WAIT_MAX           4'hE

// Area number of the extended area
`define AREA4                   3'h4

`endif

// *** sync_two_ff.v ***
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module sync_two_ff (
   input  wire ref_clk_i,     // System clock
   input  wire srst_i,        // Synchronous reset
   input  wire ce_i,          // Clock enable
   input  wire async_i,       // Level from outside the clock domain
   input  wire rst_val_i,     // Idle level loaded by reset
   output reg  sync_o         // Synchronised level
);
   reg meta_q;                // First stage, read only by the second

   // Two stages; reset loads the idle level so no false edge follows
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_q <= rst_val_i;
         sync_o <= rst_val_i;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // sync_two_ff

// *** cycle_counter.v ***
// Loadable down counter used for phase lengths and idle gaps
`timescale 1ns/1ps
module cycle_counter #(
   parameter W = 4            // Counter width
) (
   input  wire         ref_clk_i,   // System clock
   input  wire         srst_i,      // Synchronous reset
   input  wire         ce_i,        // Clock enable
   input  wire         load_i,      // Load a new count
   input  wire [W-1:0] load_val_i,  // Count to load
   input  wire         dec_i,       // Count down by one
   output reg  [W-1:0] count_o,     // Present count
   output wire         zero_o       // Count has reached zero
);
   assign zero_o = (count_o == {W{1'b0}});

   // Load wins over decrement; never wraps below zero
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         count_o <= {W{1'b0}};
      end else if (ce_i) begin
         if (load_i) begin
            count_o <= load_val_i;
         end else if (dec_i && !zero_o) begin
            count_o <= count_o - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // cycle_counter

// *** cs_space_wait_strobe_timing.v ***
// Chip-select space strobe, wait and idle timing for areas 0 to 4
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "cs_timing_map.vh"
module cs_space_wait_strobe_timing (
   input  wire        ref_clk_i,          // System clock, 250 MHz
   input  wire        srst_i,             // Synchronous reset, active high
   input  wire        ce_i,               // Clock enable, freezes all state
   input  wire [3:0]  reg_addr_i,         // Register byte address
   input  wire [15:0] reg_wdata_i,        // Register write data
   input  wire        reg_we_i,           // Register write strobe
   input  wire        reg_re_i,           // Register read strobe
   output reg  [15:0] reg_rdata_o,        // Read data, cycle after read strobe
   input  wire        req_i,              // Access request, held until ack
   input  wire [2:0]  req_area_i,         // Target area 0 to 4
   input  wire        req_write_i,        // 1 write, 0 read
   input  wire        req_sdram_i,        // Target space is synchronous DRAM
   input  wire [3:0]  long_wait_cnt_i,    // Long wait count for target area
   input  wire [7:0]  area_wait_code_i,   // Wait codes, areas 3..0
   input  wire [7:0]  area_idle_code_i,   // Idle gap codes, areas 3..0
   input  wire        ext_wait_n_i,       // External wait pin, low = wait
   output reg         ack_o,              // Request taken, one cycle
   output reg         done_o,             // Access finished, one cycle
   output reg  [4:0]  chip_select_n_o,    // Chip selects, active low
   output reg         addr_valid_o,       // Address driven
   output reg         rd_n_o,             // Read strobe, active low
   output reg         we_n_o              // Write strobe, active low
);
   // Access states
   localparam [2:0] ST_IDLE    = 3'h0;
   localparam [2:0] ST_SETUP   = 3'h1;
   localparam [2:0] ST_STROBE  = 3'h2;
   localparam [2:0] ST_RELEASE = 3'h3;
   localparam [2:0] ST_HOLD    = 3'h4;

   reg  [15:0] wait_control_2_q;    // Area 4 wait, mask, idle
   reg  [15:0] wait_control_3_q;    // Setup and hold lengths
   reg  [2:0]  state_q;             // Access state
   reg  [2:0]  area_q;              // Area of current or last access
   reg         write_q;             // Direction of current or last access
   reg         ext_en_q;            // External wait honoured this access
   reg         waited_q;            // Wait seen asserted this access
   reg  [3:0]  wait_cnt_q;          // Latched strobe length minus one
   reg  [3:0]  hold_cnt_q;          // Latched address hold minus one
   reg  [3:0]  release_cnt_q;       // Latched release delay minus one
   reg  [3:0]  gap_len_q;           // Latched idle gap of this area

   wire        wait_sync;           // Synchronised wait pin, low = wait
   wire        wait_act = ~wait_sync;
   wire [3:0]  phase_cnt;           // Phase counter value
   wire        phase_zero;          // Phase counter at zero
   wire        gap_zero;            // No idle gap pending

   reg         phase_load;          // Phase counter controls
   reg  [3:0]  phase_val;
   reg         gap_load;            // Gap counter load at access end

   // Wait pin comes from outside: two flops before any use
   sync_two_ff u_wait_sync (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .async_i   (ext_wait_n_i),
      .rst_val_i (1'b1),
      .sync_o    (wait_sync)
   );

   // Phase lengths: setup, strobe, release, hold
   cycle_counter #(.W(4)) u_phase_cnt (
      .ref_clk_i  (ref_clk_i),
      .srst_i     (srst_i),
      .ce_i       (ce_i),
      .load_i     (phase_load),
      .load_val_i (phase_val),
      .dec_i      (1'b1),
      .count_o    (phase_cnt),
      .zero_o     (phase_zero)
   );

   // Idle gap after an access
   cycle_counter #(.W(4)) u_gap_cnt (
      .ref_clk_i  (ref_clk_i),
      .srst_i     (srst_i),
      .ce_i       (ce_i),
      .load_i     (gap_load),
      .load_val_i (gap_len_q),
      .dec_i      (1'b1),
      .count_o    (),
      .zero_o     (gap_zero)
   );

   // Decode of the target area's codes, taken at request time
   reg  [1:0]  wsel;                // Wait code of target area
   reg  [1:0]  isel;                // Idle code of target area
   reg  [1:0]  shsel;               // Setup/hold code, areas 0-3
   reg         mask;                // Wait mask of target area
   reg  [3:0]  setup_m1;            // Setup cycles minus one
   reg  [3:0]  hold_m1;             // Address hold cycles minus one
   reg  [3:0]  waits;               // Wait states before wait sampling
   reg  [3:0]  idle_n;              // Idle gap cycles
   reg  [3:0]  rel_m1;              // Release delay minus one
   reg  [3:0]  lw;                  // Clamped long wait count

   always @* begin
      wsel  = 2'h0;
      isel  = 2'h0;
      shsel = 2'h0;
      if (req_area_i == `AREA4) begin
         wsel = wait_control_2_q[`WAIT_SEL_HI:`WAIT_SEL_LO];
         isel = wait_control_2_q[`IDLE_GAP_HI:`IDLE_GAP_LO];
      end else begin
         wsel  = area_wait_code_i[req_area_i[1:0]*2 +: 2];
         isel  = area_idle_code_i[req_area_i[1:0]*2 +: 2];
         shsel = wait_control_3_q[req_area_i[1:0]*2 +: 2];
      end
      // Mask bit per area; out-of-range area reads as masked
      mask = (req_area_i > `AREA4) ? 1'b1 :
             wait_control_2_q[`EXT_WAIT_MASK_LO + req_area_i];
      // Long wait clamped into its legal range
      lw = long_wait_cnt_i;
      if (lw < `LONG_WAIT_MIN) lw = `LONG_WAIT_MIN;
      if (lw > `LONG_WAIT_MAX) lw = `LONG_WAIT_MAX;
      // Wait states from the wait code
      case (wsel)
         2'h0:    waits = 4'h0;
         2'h1:    waits = 4'h1;
         2'h2:    waits = 4'h2;
         default: waits = lw;
      endcase
      // Idle gap cycles
      case (isel)
         2'h0:    idle_n = 4'h0;
         2'h1:    idle_n = 4'h1;
         2'h2:    idle_n = 4'h2;
         default: idle_n = 4'h4;
      endcase
      // Half-cycle setups round up to whole clocks
      if (req_area_i == `AREA4) begin
         case (wait_control_3_q[`SETUP_LEN_HI:`SETUP_LEN_LO])
            3'h0:    setup_m1 = 4'h0;                           // 0.5
            3'h1:    setup_m1 = 4'h1;                           // 1.5
            3'h2:    setup_m1 = 4'h3;                           // 3.5
            3'h3:    setup_m1 = 4'h5;                           // 5.5
            default: setup_m1 = 4'h7;                           // 7.5
         endcase
         case (wait_control_3_q[`HOLD_LEN_HI:`HOLD_LEN_LO])
            2'h0:    hold_m1 = 4'h0;                            // 0.5, cs 0
            2'h1:    hold_m1 = 4'h1;                            // 1.5, cs 1
            2'h2:    hold_m1 = 4'h3;                            // 3.5, cs 3
            default: hold_m1 = 4'h5;                            // 5.5, cs 5
         endcase
      end else begin
         // Reserved code 11 treated as the longest legal one
         case (shsel)
            2'h0:    setup_m1 = 4'h0;
            2'h1:    setup_m1 = 4'h1;
            default: setup_m1 = 4'h2;
         endcase
         hold_m1 = setup_m1;
      end
      // Release delay after wait negation, reserved code acts as 4
      case (wait_control_2_q[`RELEASE_DELAY_HI:`RELEASE_DELAY_LO])
         2'h0:    rel_m1 = 4'h0;
         2'h1:    rel_m1 = 4'h1;
         default: rel_m1 = 4'h3;
      endcase
   end

   // Idle gap needed unless same area and not read-then-write
   wire same_ok  = (req_area_i == area_q) && !(req_write_i && !write_q);
   wire gap_ok   = gap_zero || same_ok;
   wire take     = (state_q == ST_IDLE) && req_i && gap_ok;

   // Access sequencer
   always @* begin
      phase_load = 1'b0;
      phase_val  = 4'h0;
      gap_load   = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               phase_load = 1'b1;
               phase_val  = setup_m1;
            end
         end
         ST_SETUP: begin
            if (phase_zero) begin
               phase_load = 1'b1;
               phase_val  = wait_cnt_q;
            end
         end
         ST_STROBE: begin
            if (phase_zero && !(ext_en_q && wait_act)) begin
               phase_load = 1'b1;
               phase_val  = (waited_q && area_q == `AREA4) ? release_cnt_q : hold_cnt_q;
            end
         end
         ST_RELEASE: begin
            if (phase_zero) begin
               phase_load = 1'b1;
               phase_val  = hold_cnt_q;
            end
         end
         ST_HOLD: begin
            gap_load = phase_zero;
         end
         default: begin
            phase_load = 1'b0;
         end
      endcase
   end

   // State, latched timing and pin outputs
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_q         <= ST_IDLE;
         area_q          <= 3'h0;
         write_q         <= 1'b0;
         ext_en_q        <= 1'b0;
         waited_q        <= 1'b0;
         wait_cnt_q      <= 4'h0;
         hold_cnt_q      <= 4'h0;
         release_cnt_q   <= 4'h0;
         gap_len_q       <= 4'h0;
         ack_o           <= 1'b0;
         done_o          <= 1'b0;
         chip_select_n_o <= 5'h1F;
         addr_valid_o    <= 1'b0;
         rd_n_o          <= 1'b1;
         we_n_o          <= 1'b1;
      end else if (ce_i) begin
         ack_o  <= 1'b0;
         done_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  // Timing frozen for the whole access
                  area_q        <= req_area_i;
                  write_q       <= req_write_i;
                  wait_cnt_q    <= waits;
                  hold_cnt_q    <= hold_m1;
                  release_cnt_q <= rel_m1;
                  gap_len_q     <= idle_n;
                  // Wait honoured only if unmasked, coded and not SDRAM
                  ext_en_q      <= !mask && (wsel != 2'h0) && !req_sdram_i;
                  waited_q      <= 1'b0;
                  ack_o         <= 1'b1;
                  addr_valid_o  <= 1'b1;
                  chip_select_n_o <= ~(5'h01 << req_area_i);
                  state_q       <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (phase_zero) begin
                  rd_n_o  <= write_q;
                  we_n_o  <= ~write_q;
                  state_q <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (phase_zero) begin
                  if (ext_en_q && wait_act) begin
                     waited_q <= 1'b1;                          // Stretch while wait held
                  end else if (waited_q && area_q == `AREA4) begin
                     state_q <= ST_RELEASE;
                  end else begin
                     rd_n_o  <= 1'b1;
                     we_n_o  <= 1'b1;
                     if (hold_cnt_q == 4'h0) chip_select_n_o <= 5'h1F;
                     state_q <= ST_HOLD;
                  end
               end
            end
            ST_RELEASE: begin
               if (phase_zero) begin
                  rd_n_o  <= 1'b1;
                  we_n_o  <= 1'b1;
                  if (hold_cnt_q == 4'h0) chip_select_n_o <= 5'h1F;
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               // Chip select drops one clock before the address
               if (phase_cnt == 4'h1) chip_select_n_o <= 5'h1F;
               if (phase_zero) begin
                  chip_select_n_o <= 5'h1F;
                  addr_valid_o    <= 1'b0;
                  done_o          <= 1'b1;
                  state_q         <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Register writes; reserved bits never stored
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         wait_control_2_q <= `WAIT_CONTROL_2_RST;
         wait_control_3_q <= `WAIT_CONTROL_3_RST;
      end else if (ce_i && reg_we_i) begin
         if (reg_addr_i == `WAIT_CONTROL_2_OFS)
            wait_control_2_q <= reg_wdata_i & `WAIT_CONTROL_2_WMASK;
         if (reg_addr_i == `WAIT_CONTROL_3_OFS)
            wait_control_3_q <= reg_wdata_i & `WAIT_CONTROL_3_WMASK;
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (ce_i) begin
         reg_rdata_o <= 16'h0000;
         if (reg_re_i) begin
            case (reg_addr_i)
               `WAIT_CONTROL_2_OFS: reg_rdata_o <= wait_control_2_q;
               `WAIT_CONTROL_3_OFS: reg_rdata_o <= wait_control_3_q;
               `TIMING_STATUS_OFS:  reg_rdata_o <= {6'h00, gap_zero, waited_q,
                                                   ext_en_q, write_q, area_q, state_q};
               default:             reg_rdata_o <= 16'h0000;
            endcase
         end
      end
   end
endmodule // cs_space_wait_strobe_timing

// *** ext_device_model.sv ***
// External device model driving the wait pin
`timescale 1ns/1ps
module ext_device_model (
   input  wire       ref_clk_i,    // System clock
   input  wire [4:0] cs_n_i,       // Chip selects from the block, active low
   input  wire [7:0] stall_i,      // Wait length in cycles, 0 answers at once
   output reg        ext_wait_n_o  // Wait pin, pulled up when released
);
   reg [7:0] left_q = 8'h00;       // Wait cycles still to hold
   reg       sel_q = 1'b0;         // Selected in the last cycle
   initial begin
      ext_wait_n_o = 1'b1;
   end
   // New selection starts one wait burst, then pull-up level
   always @(posedge ref_clk_i) begin
      sel_q <= (cs_n_i != 5'h1F);
      if ((cs_n_i != 5'h1F) && !sel_q)
         left_q <= stall_i;
      else if (left_q != 8'h00)
         left_q <= left_q - 8'h01;
      ext_wait_n_o <= !(((cs_n_i != 5'h1F) && !sel_q && (stall_i != 8'h00)) || (left_q > 8'h01));
   end
endmodule // ext_device_model

// *** cs_timing_chk_sva.sv ***
// Concurrent checks on the ports of the chip-select timing block
`timescale 1ns/1ps
`include "cs_timing_map.vh"
module cs_timing_chk (
   input wire        ref_clk_i,        // System clock
   input wire        srst_i,
   input wire        ce_i,
   input wire [3:0]  reg_addr_i,
   input wire        reg_re_i,
   input wire [15:0] reg_rdata_o,
   input wire        req_i,
   input wire [2:0]  req_area_i,
   input wire        ack_o,
   input wire        done_o,
   input wire [4:0]  chip_select_n_o,
   input wire        addr_valid_o,
   input wire        rd_n_o,
   input wire        we_n_o
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   AST_RDATA_QUIET: assert property (ce_i && !reg_re_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero");
   AST_W2_SPARE: assert property (ce_i && reg_re_i && reg_addr_i == `WAIT_CONTROL_2_OFS
      |=> (reg_rdata_o & ~`WAIT_CONTROL_2_WMASK) == 16'h0000) else $error("unused bit set");
   AST_W3_SPARE: assert property (ce_i && reg_re_i && reg_addr_i == `WAIT_CONTROL_3_OFS
      |=> (reg_rdata_o & ~`WAIT_CONTROL_3_WMASK) == 16'h0000) else $error("unused bit set");
   AST_STROBE_SOLO: assert property (!rd_n_o |-> we_n_o)
      else $error("both strobes low");
   AST_STROBE_IN_CS: assert property ((!rd_n_o || !we_n_o) |-> addr_valid_o
      && chip_select_n_o != 5'h1F) else $error("strobe outside address phase");
   AST_SETUP_LEAD: assert property ($fell(rd_n_o && we_n_o) |->
      $past(chip_select_n_o) != 5'h1F && $past(addr_valid_o)) else $error("no setup");
   AST_CS_DROPS_FIRST: assert property (done_o |-> !addr_valid_o
      && $past(chip_select_n_o) == 5'h1F) else $error("select held past address");
   AST_ACK_SELECTS: assert property (ack_o && $past(req_area_i) <= 3'h4 |-> $past(req_i)
      && chip_select_n_o == ~(5'h01 << $past(req_area_i))) else $error("wrong select");
   AST_ACK_TO_DONE: assert property (ack_o |-> ##[3:400] done_o)
      else $error("access never ends");
   AST_ACK_SPACING: assert property (ack_o |=> (!ack_o) [*3])
      else $error("requests too close");
   AST_ONE_AREA: assert property ($onehot0(~chip_select_n_o))
      else $error("several selects low");
   COV_AREA4: cover property (ack_o && !chip_select_n_o[4]);
   COV_STRETCH: cover property ((!rd_n_o) [*8]);
   COV_BACK_TO_BACK: cover property (done_o ##[1:3] ack_o);
endmodule // cs_timing_chk
bind cs_space_wait_strobe_timing cs_timing_chk cs_timing_chk_i (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
   .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_area_i(req_area_i),
   .ack_o(ack_o), .done_o(done_o), .chip_select_n_o(chip_select_n_o),
   .addr_valid_o(addr_valid_o), .rd_n_o(rd_n_o), .we_n_o(we_n_o));

// *** testbench.sv ***
// Self-checking bench for chip-select wait, strobe and idle timing
`timescale 1ns/1ps
`include "cs_timing_map.vh"
module testbench;
   typedef struct {int s; int wl; int wh; int ch; int h; int g;} rec_t;
   logic        ref_clk_i = 1'b0;         // System clock
   logic        srst_i = 1'b1;
   logic        ce_i = 1'b1;              // Held on
   logic [3:0]  reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_we_i = 1'b0;
   logic        reg_re_i = 1'b0;
   logic        req_i = 1'b0;
   logic [2:0]  req_area_i = 3'h0;
   logic        req_write_i = 1'b0;
   logic        req_sdram_i = 1'b0;
   logic [3:0]  long_wait_cnt_i = 4'h0;
   logic [7:0]  area_wait_code_i = 8'h00; // Areas 0-3 wait codes
   logic [7:0]  area_idle_code_i = 8'h00; // Areas 0-3 idle codes
   logic [7:0]  stall = 8'h00;            // Partner wait length
   wire  [15:0] reg_rdata_o;
   wire         ext_wait_n_i;             // Wait pin
   wire         ack_o, done_o, addr_valid_o, rd_n_o, we_n_o;
   wire  [4:0]  chip_select_n_o;
   int n_errors = 0, check_count = 0, n_s, n_w, n_c, n_h, n_idle = 0, ph = 0;
   int i, a, c, v, lw_c, ws;
   int s4[5] = '{1, 2, 4, 6, 8};          // Area 4 setup clocks
   int h4[4] = '{1, 2, 4, 6};             // Area 4 hold clocks
   int lw[6] = '{0, 0, 0, 1, 15, 7};      // Long wait counts
   int we4[6] = '{1, 2, 3, 4, 15, 8};     // Strobe clocks, masked
   int ig[4] = '{0, 1, 2, 4};             // Idle cycles per code
   int lo[5] = '{1, 2, 6, 7, 9};          // Strobe lower bounds with stall
   int hi[5] = '{1, 2, 10, 11, 13};       // Strobe upper bounds with stall
   logic [15:0] w2t[5] = '{16'h0000, 16'h0001, 16'h0002, 16'h4002, 16'h8002}; // Settings
   logic        sdt[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}; // DRAM flags
   logic [15:0] rq[$];                    // Expected read data
   logic [15:0] ev;
   rec_t        aq[$];                    // Expected access shapes
   rec_t        er;
   logic        rd_pend = 1'b0;           // Read answer due
   cs_space_wait_strobe_timing cs_space_wait_strobe_timing_i (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_area_i(req_area_i),
      .req_write_i(req_write_i), .req_sdram_i(req_sdram_i), .long_wait_cnt_i(long_wait_cnt_i),
      .area_wait_code_i(area_wait_code_i), .area_idle_code_i(area_idle_code_i),
      .ext_wait_n_i(ext_wait_n_i), .ack_o(ack_o), .done_o(done_o),
      .chip_select_n_o(chip_select_n_o), .addr_valid_o(addr_valid_o), .rd_n_o(rd_n_o),
      .we_n_o(we_n_o));
   ext_device_model ext_device_model_i (.ref_clk_i(ref_clk_i), .cs_n_i(chip_select_n_o),
      .stall_i(stall), .ext_wait_n_o(ext_wait_n_i));
   // 250 MHz clock
   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   // Range compare; an unknown never passes
   task automatic chk(input string nm, input int lo_v, input int hi_v, input logic [15:0] got);
      check_count++;
      if ((^got === 1'bX) || (got < lo_v) || (got > hi_v)) begin
         n_errors++;
         $display("BAD %s expected %0d..%0d seen %0d", nm, lo_v, hi_v, got);
      end
   endtask
   // Strobes stay up between calls
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      reg_re_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [3:0] ad, input logic [15:0] e);
      rq.push_back(e);
      reg_addr_i <= ad;
      reg_re_i <= 1'b1;
      reg_we_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic bus_off();
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   function automatic rec_t mk(int s, int wl, int wh, int ch, int h, int g);
      return '{s, wl, wh, ch, h, g};
   endfunction
   // Request held until ack, then bounded wait for done
   task automatic acc(input logic [2:0] ar, input logic w, input logic sd, input rec_t e);
      int k;
      k = 0;
      aq.push_back(e);
      req_area_i <= ar;
      req_write_i <= w;
      req_sdram_i <= sd;
      req_i <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while ((ack_o !== 1'b1) && (k < 400));
      req_i <= 1'b0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while ((done_o !== 1'b1) && (k < 800));
      if (k >= 800) chk("access_end", 0, 0, 16'h0001);
   endtask
   // Measures accesses on settled outputs
   always @(negedge ref_clk_i) begin
      if (rd_pend) begin
         ev = rq.pop_front();
         chk("reg_rdata_o", ev, ev, reg_rdata_o);
      end
      rd_pend = reg_re_i;
      if (ack_o === 1'b1) begin
         ph = 1;
         n_s = 0;
         n_w = 0;
         n_c = 0;
         n_h = 0;
         if (aq.size() > 0) chk("idle_gap", aq[0].g, 65535, n_idle[15:0]);
      end
      if ((done_o === 1'b1) && (aq.size() > 0)) begin
         er = aq.pop_front();
         chk("setup", er.s, er.s, n_s);
         chk("strobe", er.wl, er.wh, n_w);
         chk("cs_hold", er.ch, er.ch, n_c);
         chk("addr_hold", er.h, er.h, n_h);
         n_idle = 0;
      end
      if (addr_valid_o === 1'b1) begin
         if ((rd_n_o & we_n_o) !== 1'b1) begin
            n_w++;
            ph = 2;
         end else if (ph == 1) n_s++;
         else begin
            n_h++;
            if (chip_select_n_o !== 5'h1F) n_c++;
         end
      end else if (n_idle < 60000) n_idle++;
   end
   // Verdict
   task automatic final_report();
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if ((n_errors == 0) && (check_count > 0))
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      n_errors++;
      final_report();
   end
   initial begin
      v = $urandom(22);
      repeat (10) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd(`WAIT_CONTROL_2_OFS, `WAIT_CONTROL_2_RST);
      rd(`WAIT_CONTROL_3_OFS, `WAIT_CONTROL_3_RST);
      wr(`WAIT_CONTROL_2_OFS, 16'hFFFF);
      wr(`WAIT_CONTROL_3_OFS, 16'hFFFF);
      rd(`WAIT_CONTROL_2_OFS, `WAIT_CONTROL_2_WMASK);
      rd(`WAIT_CONTROL_3_OFS, `WAIT_CONTROL_3_WMASK);
      rd(4'hC, 16'h0000);
      rd(`TIMING_STATUS_OFS, 16'h0200);
      wr(`WAIT_CONTROL_2_OFS, 16'h1000);
      // Area 4 setup and hold codes
      for (i = 0; i < 5; i++) begin
         wr(`WAIT_CONTROL_3_OFS, {2'b00, i[2:0], 1'b0, i[1:0], 8'h00});
         bus_off();
         acc(3'h4, i[0], 1'b0, mk(s4[i], 1, 1, h4[i % 4] - 1, h4[i % 4], 0));
      end
      // Masked: strobe length from code and long wait count alone
      wr(`WAIT_CONTROL_3_OFS, 16'h0000);
      stall <= 8'd6;
      for (i = 0; i < 6; i++) begin
         wr(`WAIT_CONTROL_2_OFS, 16'h1000 | 16'((i < 3) ? i : 3));
         bus_off();
         long_wait_cnt_i <= lw[i][3:0];
         acc(3'h4, 1'b0, 1'b0, mk(1, we4[i], we4[i], 0, 1, 0));
      end
      // Unmasked: stretch and release
      wr(`WAIT_CONTROL_3_OFS, 16'h1000);
      stall <= 8'd8;
      for (i = 0; i < 5; i++) begin
         wr(`WAIT_CONTROL_2_OFS, w2t[i]);
         bus_off();
         acc(3'h4, 1'b0, sdt[i], mk(4, lo[i], hi[i], 0, 1, 0));
      end
      // Idle gaps
      stall <= 8'd0;
      area_idle_code_i <= 8'h03;
      wr(`WAIT_CONTROL_3_OFS, 16'h0000);
      for (i = 0; i < 4; i++) begin
         wr(`WAIT_CONTROL_2_OFS, 16'h1000 | 16'(i << 2));
         bus_off();
         acc(3'h4, 1'b0, 1'b0, mk(1, 1, 1, 0, 1, 0));
         acc(3'h4, 1'b1, 1'b0, mk(1, 1, 1, 0, 1, ig[i]));
      end
      wr(`WAIT_CONTROL_2_OFS, 16'h1000);
      bus_off();
      acc(3'h0, 1'b0, 1'b0, mk(1, 1, 1, 0, 1, 0));
      acc(3'h4, 1'b0, 1'b0, mk(1, 1, 1, 0, 1, 4));
      // Random areas 0-3 with all masks set
      wr(`WAIT_CONTROL_2_OFS, 16'h1F00);
      for (i = 0; i < 24; i++) begin
         a = $urandom % 4;
         c = $urandom % 3;
         v = $urandom;
         lw_c = $urandom % 16;
         ws = (v >> (2 * a)) & 3;
         ws = (ws < 3) ? ws + 1 : (lw_c < 3) ? 4 : (lw_c > 14) ? 15 : lw_c + 1;
         wr(`WAIT_CONTROL_3_OFS, 16'(c << (2 * a)));
         bus_off();
         area_wait_code_i <= v[7:0];
         area_idle_code_i <= v[15:8];
         long_wait_cnt_i <= lw_c[3:0];
         acc(a[2:0], v[16], 1'b0, mk(c + 1, ws, ws, c, c + 1, 0));
      end
      repeat (5) @(posedge ref_clk_i);
      final_report();
   end
endmodule // testbench
